/* File: hw/terminal_char_port.sv */
// Controller end of the keyboard and printer character port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - a print buffer write pulses the print strobe and presents the character.
// - while printer request is low the ready latch cannot set.
// - each key strobe loads the seven keyboard lines into the buffer.
// - the controller adds an eighth bit of its own to the keyboard byte.
// - the controller drives a printer initialise line.
// - characters travel as seven-bit codes on seven parallel lines.
// - rising request sets ready latch, status bit 7, interrupt gated by bit 6.
// - host bit n drives printer line n+1, inverted at the pins.
// - keyboard line k reads on bit k-1; key strobe sets done flag bit 7.
// - no overrun flag; an unread character is overwritten.
module terminal_char_port
    import char_port_pkg::*;
(
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    // Host side.
    input  wire host_req_t  hostReq,
    input  wire logic       eighthBitSel,
    input  wire logic       eighthBitVal,
    input  wire logic       initReq,
    output host_view_t      hostView,
    output logic            printIrq,
    output logic            keyIrq,
    // Terminal side.
    input  wire term_in_t   termIn,
    output term_out_t       termOut
);
    typedef struct packed {
        logic [6:0] keyBuf;
        logic       keyDone;
        logic       ready;
        logic       ie;
        logic [6:0] printData;
        logic [2:0] strobeCnt;
        logic       initN;
        logic [7:0] keyByte;
    } state_t;

    state_t st;
    state_t next_st;
    logic   keyLevel;
    logic   keyFall;
    logic   reqLevel;
    logic   reqRise;
    logic   keyStrobeSeen;

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    // The keyboard lines settle before the strobe, so they are sampled
    // when the synchronised strobe edge is seen.
    logic [6:0] kbMeta;
    logic [6:0] kbSync;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            kbMeta <= RST_CHAR;
            kbSync <= RST_CHAR;
        end else begin
            kbMeta <= termIn.keyboardCharLines;
            kbSync <= kbMeta;
        end
    end

    edge_sync u_key_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .async   (termIn.keyStrobeN),
        .level   (keyLevel),
        .rise    (),
        .fall    (keyFall)
    );

    edge_sync u_req_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .async   (termIn.printerRequest),
        .level   (reqLevel),
        .rise    (reqRise),
        .fall    ()
    );

    assign keyStrobeSeen = keyFall;

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        next_st = st;
        next_st.initN = ~initReq;
        if (hostReq.writePrintStat) begin
            next_st.ie = hostReq.wdata[STAT_IE_B];
        end
        if (st.strobeCnt != 3'h0) begin
            next_st.strobeCnt = st.strobeCnt - 3'h1;
        end
        if (hostReq.writePrintBuf) begin
            next_st.printData = hostReq.wdata[CHAR_W-1:0];
            next_st.strobeCnt = STROBE_CYC_W;
            next_st.ready     = 1'b0;
        end
        if (!reqLevel) begin
            next_st.ready = 1'b0;
        end else if (reqRise) begin
            next_st.ready = 1'b1;
        end
        if (hostReq.readKeyBuf) begin
            next_st.keyDone = 1'b0;
        end
        if (keyStrobeSeen) begin
            next_st.keyBuf  = kbSync;
            next_st.keyDone = 1'b1;
        end
        next_st.keyByte = {eighthBitSel & eighthBitVal, st.keyBuf};
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
            st.initN <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    always_comb begin
        termOut.printStrobeN     = (st.strobeCnt == 3'h0);
        termOut.printerCharLines = ~st.printData;
        termOut.printerInitN     = st.initN;
        hostView.keyBuf          = st.keyByte;
        hostView.keyStat         = {st.keyDone, 7'h00};
        hostView.printStat       = {st.ready, st.ie, 6'h00};
        printIrq                 = st.ready & st.ie;
        keyIrq                   = st.keyDone;
    end

    // ==========================================================
    // Checks
    // ==========================================================
    sequence hostPrint_s;
        hostReq.writePrintBuf;
    endsequence

    sequence strobeHeld_s;
        !termOut.printStrobeN [*4];
    endsequence

    strobe_on_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        hostPrint_s |=> strobeHeld_s ##1 termOut.printStrobeN)
        else $error("print strobe not four cycles after write");

    data_on_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        hostReq.writePrintBuf |=> termOut.printerCharLines == ~$past(hostReq.wdata[6:0]))
        else $error("printer lines wrong after write");

    ready_low_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        !reqLevel |=> !hostView.printStat[7])
        else $error("ready set while request low");

    ready_rise_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        reqRise && !hostReq.writePrintBuf |=> hostView.printStat[7])
        else $error("ready not set by request rise");

    print_irq_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        printIrq == (hostView.printStat[7] && hostView.printStat[6]))
        else $error("print interrupt not gated by enable");

    key_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        keyStrobeSeen |=> keyIrq ##1 hostView.keyBuf[6:0] == $past(kbSync, 2))
        else $error("keyboard character not loaded");

    key_done_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        keyStrobeSeen |=> hostView.keyStat[7])
        else $error("done flag not set by key strobe");

    eighth_bit_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        !eighthBitSel |=> !hostView.keyBuf[7])
        else $error("eighth bit set while not selected");

    init_line_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        initReq |=> !termOut.printerInitN)
        else $error("init line not driven");

    sync_delay_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        keyFall |-> !keyLevel)
        else $error("key edge without synchronised level");
endmodule // terminal_char_port
`default_nettype wire

/* File: common/char_port_pkg.sv */
// Package with the constants and carrier types of the terminal character port.
package char_port_pkg;

    // ==========================================================
    // Character widths and status bit positions
    // ==========================================================
    localparam int CHAR_W        = 7;
    localparam int BUS_W         = 8;
    localparam int STAT_READY_B  = 7;
    localparam int STAT_IE_B     = 6;
    localparam int STAT_DONE_B   = 7;
    localparam int STROBE_TIME_NS = 20;
    localparam int CLK_PERIOD_NS  = 5;
    localparam int STROBE_CYC    = (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] STROBE_CYC_W = 3'(STROBE_CYC);

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [6:0] RST_CHAR  = 7'h00;
    localparam logic [7:0] RST_BYTE  = 8'h00;

    // ==========================================================
    // Carrier types
    // ==========================================================
    // Lines arriving from the terminal.
    typedef struct packed {
        logic       keyStrobeN;
        logic [6:0] keyboardCharLines;
        logic       printerRequest;
    } term_in_t;

    // Lines driven to the terminal.
    typedef struct packed {
        logic       printStrobeN;
        logic [6:0] printerCharLines;
        logic       printerInitN;
    } term_out_t;

    // Host side request and read data.
    typedef struct packed {
        logic       writePrintBuf;
        logic       writePrintStat;
        logic       readKeyBuf;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic [7:0] keyBuf;
        logic [7:0] keyStat;
        logic [7:0] printStat;
    } host_view_t;

endpackage

/* File: hw/edge_sync.sv */
// Two-flop synchroniser with rise and fall detect on the second stage.
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic resetn,
    // Asynchronous input and synchronised results.
    input  wire logic async,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta;
    logic s1;
    logic s2;

    // ==========================================================
    // Synchroniser chain
    // ==========================================================
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta <= 1'b0;
            s1   <= 1'b0;
            s2   <= 1'b0;
        end else begin
            meta <= async;
            s1   <= meta;
            s2   <= s1;
        end
    end

    assign level = s1;
    assign rise  = s1 & ~s2;
    assign fall  = ~s1 & s2;
endmodule // edge_sync
`default_nettype wire

/* File: bench/terminal_model.sv */
// Behavioural terminal that sends keyboard characters and accepts printer characters.
`timescale 1ns/1ps
`default_nettype none
module terminal_model
    import char_port_pkg::*;
(
    // Clock used for pacing only.
    input  wire logic      ref_clk,
    // Terminal pins.
    input  wire term_out_t termOut,
    output term_in_t       termIn,
    // Last character taken by the printer.
    output logic [6:0]     printedChar
);
    int busyCnt;

    // The request starts low so that its first rise comes after reset.
    initial begin
        termIn = '{keyStrobeN: 1'b1, keyboardCharLines: 7'h2A, printerRequest: 1'b0};
        busyCnt = 20;
        printedChar = 7'h00;
    end

    always @(negedge ref_clk) begin
        if (termOut.printStrobeN === 1'b0 && busyCnt == 0) begin
            printedChar <= ~termOut.printerCharLines;
            termIn.printerRequest <= 1'b0;
            busyCnt <= 12;
        end else if (busyCnt > 1) begin
            busyCnt <= busyCnt - 1;
        end else if (busyCnt == 1 && termIn.keyStrobeN) begin
            busyCnt <= 0;
            termIn.printerRequest <= 1'b1;
        end
    end

    // The request is dropped before the key strobe so both are never active.
    task automatic sendKey(input logic [6:0] ch);
        @(negedge ref_clk);
        termIn.keyboardCharLines = ch;
        termIn.printerRequest = 1'b0;
        repeat (4) @(negedge ref_clk);
        termIn.keyStrobeN = 1'b0;
        repeat (4) @(negedge ref_clk);
        termIn.keyStrobeN = 1'b1;
        termIn.keyboardCharLines = ~ch;
        termIn.printerRequest = (busyCnt == 0);
    endtask
endmodule // terminal_model
`default_nettype wire

/* File: bench/terminal_char_port_bench.sv */
// Self-checking bench for the terminal character port.
`timescale 1ns/1ps
`default_nettype none
module terminal_char_port_bench
    import char_port_pkg::*;
;
    logic       ref_clk;
    logic       resetn;
    host_req_t  hostReq;
    logic       eighthBitSel;
    logic       eighthBitVal;
    logic       initReq;
    host_view_t hostView;
    logic       printIrq;
    logic       keyIrq;
    term_in_t   termIn;
    term_out_t  termOut;
    logic [6:0] printedChar;
    int         error_cnt;
    int         check_count;

    terminal_char_port u_terminal_char_port (.ref_clk(ref_clk), .resetn(resetn),
        .hostReq(hostReq), .eighthBitSel(eighthBitSel), .eighthBitVal(eighthBitVal),
        .initReq(initReq), .hostView(hostView), .printIrq(printIrq), .keyIrq(keyIrq),
        .termIn(termIn), .termOut(termOut));
    terminal_model u_terminal_model (.ref_clk(ref_clk), .termOut(termOut), .termIn(termIn),
        .printedChar(printedChar));

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("Checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Kind bits select print buffer write, status write and key buffer read.
    task automatic hostPulse(input logic [2:0] kind, input logic [7:0] data);
        hostReq = {kind, data};
        @(negedge ref_clk);
        hostReq = '0;
    endtask

    task automatic waitReady;
        int n;
        n = 0;
        while (hostView.printStat[7] !== 1'b1 && n < 100) begin
            n++;
            @(negedge ref_clk);
        end
        if (n == 100) begin
            error_cnt++;
            $display("Error at %0t: printer never ready", $time);
            stop_test();
        end
    endtask

    task automatic printChar(input logic [6:0] ch, input logic ie);
        int n;
        n = 0;
        hostPulse(3'b010, {1'b0, ie, 6'h00});
        waitReady();
        check(printIrq, ie);
        hostPulse(3'b100, {1'b0, ch});
        while (termOut.printStrobeN !== 1'b0 && n < 3) begin
            n++;
            @(negedge ref_clk);
        end
        check(termOut.printerCharLines, {~ch});
        n = 0;
        while (termOut.printStrobeN === 1'b0 && n < 9) begin
            n++;
            @(negedge ref_clk);
        end
        check(n[8:0], 9'h004);
        check(hostView.printStat, {1'b0, ie, 6'h00});
        check(printedChar, ch);
    endtask

    task automatic keyTest(input logic [6:0] ch, input logic sel, input logic val,
                           input logic read);
        eighthBitSel = sel;
        eighthBitVal = val;
        u_terminal_model.sendKey(ch);
        repeat (2) @(negedge ref_clk);
        check(hostView.keyStat, 8'h80);
        check(keyIrq, 1'b1);
        check(hostView.keyBuf, {sel & val, ch});
        if (read) begin
            hostPulse(3'b001, 8'h00);
            @(negedge ref_clk);
            check(keyIrq, 1'b0);
        end
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    initial begin
        error_cnt = 0;
        check_count = 0;
        resetn = 1'b0;
        hostReq = '0;
        eighthBitSel = 1'b0;
        eighthBitVal = 1'b0;
        initReq = 1'b0;
        repeat (4) @(negedge ref_clk);
        check(termOut, {1'b1, 7'h7F, 1'b1});
        check(hostView.printStat, 8'h00);
        resetn = 1'b1;
        printChar(7'h41, 1'b1);
        printChar(7'h00, 1'b0);
        printChar(7'h7F, 1'b1);
        keyTest(7'h01, 1'b1, 1'b1, 1'b1);
        keyTest(7'h40, 1'b1, 1'b0, 1'b1);
        // The unread character is overwritten by the next one.
        keyTest(7'h55, 1'b0, 1'b1, 1'b0);
        keyTest(7'h2A, 1'b0, 1'b0, 1'b1);
        printChar(7'h33, 1'b1);
        initReq = 1'b1;
        repeat (2) @(negedge ref_clk);
        check(termOut.printerInitN, 1'b0);
        initReq = 1'b0;
        repeat (2) @(negedge ref_clk);
        check(termOut.printerInitN, 1'b1);
        stop_test();
    end
endmodule // terminal_char_port_bench
`default_nettype wire
